// [rtl/ffrp_packetizer.sv]
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module ffrp_packetizer
    import ffrp_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    input  wire logic              rx_valid,
    input  wire logic [7:0]        rx_byte,
    input  wire logic              rx_first,
    input  wire logic              rx_last,
    input  wire logic              rx_crc_err,
    input  wire logic              rx_eof_missing,
    input  wire logic              rx_link_ctl,
    input  wire logic [2:0]        rx_eof_code,
    input  wire logic [3:0]        rx_sof_code,
    input  wire logic              rx_overrun,
    input  wire logic [47:0]       rtc,
    input  wire logic [63:0]       abs_time,
    output logic      [1:0]        time_fmt,
    output logic      [15:0]       pkt_data,
    output logic                   pkt_valid,
    output logic                   pkt_first,
    output logic                   pkt_last,
    output logic                   irq
);
    logic [15:0]    buf_mem [0:BUF_WORDS-1];
    ffrp_cap_e      cap_st;
    ffrp_emit_e     emit_st;
    logic [7:0]     pkt_flags;
    logic           sel_reg;
    logic [15:0]    frames_per_pkt;
    logic [IRQ_W-1:0] stat;
    logic [IRQ_W-1:0] mask;
    logic [31:0]    frames_total;
    logic [11:0]    cnt;
    logic           fault_f;
    logic           sel_f;
    logic           ovr_f;
    logic [3:0]     sof_f;
    logic [63:0]    time_f;
    logic           overrun_pend;
    logic [31:0]    id_r;
    logic [63:0]    time_r;
    logic [10:0]    used_r;
    logic [10:0]    words_r;
    logic [15:0]    pkt_cnt;
    logic [15:0]    pkt_target;
    logic [2:0]     sub;
    logic [10:0]    widx;
    logic           emit_done;
    logic           starting;
    logic           aborting;
    logic           accept;
    logic           take;
    logic           finish;
    logic           refused;
    logic [11:0]    base;
    logic [11:0]    limit;
    logic [11:0]    next_cnt;
    logic [11:0]    next_len;
    logic           next_fault;
    logic [31:0]    next_id;
    logic [15:0]    fpp_eff;
    logic           frame_end;
    logic           pkt_end;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;

    function automatic logic [11:0] round4(input logic [11:0] n);
        logic [12:0] s;
        s = {1'b0, n} + 13'd3;
        round4 = {s[11:2], 2'b00};
    endfunction : round4

    function automatic logic [15:0] hdr_word(input logic [95:0] h,
                                             input logic [2:0]  i);
        hdr_word = h[{i, 4'h0} +: 16];
    endfunction : hdr_word

    // capture decode
    always_comb
    begin
        starting   = rx_valid && rx_first && (cap_st == C_IDLE);
        aborting   = rx_valid && rx_first && (cap_st == C_CAP);
        refused    = rx_valid && rx_first && (cap_st == C_HOLD);
        accept     = starting || (rx_valid && !rx_first && cap_st == C_CAP);
        base       = starting ? 12'd0 : cnt;
        limit      = (starting ? sel_reg : sel_f) ? PAYLOAD_MAX
                                                  : FRAME_MAX;
        take       = accept && (base < limit);
        next_cnt   = take ? base + 12'd1 : base;
        finish     = (accept && rx_last) || aborting;
        // bytes past the limit are lost, so the frame is flagged
        next_fault = (!starting && fault_f) || (accept && !take)
                   || (accept && rx_last && rx_eof_missing)
                   || aborting
                   || (starting && rx_sof_code > SOF_MAX);
        next_len   = round4(next_cnt);
        next_id = 32'h0;
        // a rounded length is a framing fault too, but only at the end:
        // kept out of fault_f so early odd counts do not taint the frame
        next_id[ID_FAULT] = next_fault
                          || (next_cnt[1:0] != 2'b00);
        next_id[ID_CRC]   = accept && rx_last && rx_crc_err;
        next_id[ID_OVR]   = starting ? (overrun_pend || rx_overrun)
                                     : ovr_f;
        next_id[ID_MODE]  = !(starting ? sel_reg : sel_f);
        next_id[ID_TOP_LO +: 2] = TOP_PASSIVE;
        next_id[11:0]     = next_len;
        if (starting ? sel_reg : sel_f)
        begin
            if (accept && rx_last)
                next_id[ID_EOF_LO +: 3] = rx_eof_code;
            next_id[ID_SOF_LO +: 4] = starting ? rx_sof_code
                                               : sof_f;
        end
        else
        begin
            next_id[ID_TYPE_LO +: 2] = {1'b0, rx_link_ctl};
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cap_st <= C_IDLE;
        else
        begin
            case (cap_st)
                C_IDLE:
                    if (starting)
                        cap_st <= (rx_last) ? C_HOLD : C_CAP;
                C_CAP:
                    if (finish)
                        cap_st <= C_HOLD;
                C_HOLD:
                    if (emit_done)
                        cap_st <= C_IDLE;
                default:
                    cap_st <= C_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt     <= 12'd0;
            fault_f <= 1'b0;
            sel_f   <= 1'b0;
            ovr_f   <= 1'b0;
            sof_f   <= 4'h0;
            time_f  <= 64'h0;
        end
        else if (accept)
        begin
            cnt     <= next_cnt;
            fault_f <= next_fault;
            if (starting)
            begin
                sel_f  <= sel_reg;
                ovr_f  <= overrun_pend || rx_overrun;
                sof_f  <= rx_sof_code;
                // taken with the first byte, the closest to the first bit
                time_f <= pkt_flags[CTRL_ABS] ? abs_time
                                              : {16'h0, rtc};
            end
        end
    end

    // the word is rewritten on the odd byte; until then the high half
    // is already zero filler
    always_ff @(posedge mclk)
    begin
        if (take)
        begin
            if (base[0])
                buf_mem[base[11:1]] <= {rx_byte,
                                        buf_mem[base[11:1]][7:0]};
            else
                buf_mem[base[11:1]] <= {8'h00, rx_byte};
        end
    end

    // a frame that starts while the buffer is still draining is dropped
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            overrun_pend <= 1'b0;
        else
            overrun_pend <= (overrun_pend && !starting) || refused
                         || (aborting) || (rx_overrun && !starting);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            id_r    <= 32'h0;
            time_r  <= 64'h0;
            used_r  <= 11'd0;
            words_r <= 11'd0;
        end
        else if (finish)
        begin
            id_r    <= next_id;
            time_r  <= starting ? (pkt_flags[CTRL_ABS] ? abs_time
                                                       : {16'h0, rtc})
                                : time_f;
            used_r  <= 11'((next_cnt + 12'd1) >> 1);
            words_r <= next_len[11:1];
        end
    end

    // emission
    always_comb
    begin
        fpp_eff   = (frames_per_pkt == 16'h0) ? 16'h0001 : frames_per_pkt;
        frame_end = ((emit_st == E_HDR) && (sub == HDR_LAST)
                     && (words_r == 11'd0))
                 || ((emit_st == E_DATA) && (widx == words_r - 11'd1));
        pkt_end   = frame_end && (pkt_cnt + 16'd1 >= pkt_target);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            emit_st    <= E_IDLE;
            sub        <= 3'd0;
            widx       <= 11'd0;
            pkt_cnt    <= 16'h0;
            pkt_target <= FRAMES_RST;
            emit_done  <= 1'b0;
        end
        else
        begin
            emit_done <= 1'b0;
            case (emit_st)
                E_IDLE:
                    if (cap_st == C_HOLD && !emit_done)
                    begin
                        sub <= 3'd0;
                        if (pkt_cnt == 16'h0)
                        begin
                            pkt_target <= fpp_eff;
                            emit_st    <= E_CHAN;
                        end
                        else
                            emit_st <= E_HDR;
                    end
                E_CHAN:
                    if (sub == 3'd1)
                    begin
                        sub     <= 3'd0;
                        emit_st <= E_HDR;
                    end
                    else
                        sub <= sub + 3'd1;
                E_HDR:
                    if (sub == HDR_LAST)
                    begin
                        widx    <= 11'd0;
                        emit_st <= (words_r == 11'd0) ? E_IDLE : E_DATA;
                    end
                    else
                        sub <= sub + 3'd1;
                E_DATA:
                    if (frame_end)
                        emit_st <= E_IDLE;
                    else
                        widx <= widx + 11'd1;
                default:
                    emit_st <= E_IDLE;
            endcase
            if (frame_end)
            begin
                emit_done <= 1'b1;
                pkt_cnt   <= pkt_end ? 16'h0 : pkt_cnt + 16'd1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pkt_data  <= 16'h0;
            pkt_valid <= 1'b0;
            pkt_first <= 1'b0;
            pkt_last  <= 1'b0;
        end
        else
        begin
            pkt_valid <= emit_st != E_IDLE;
            pkt_first <= (emit_st == E_CHAN) && (sub == 3'd0);
            pkt_last  <= pkt_end;
            case (emit_st)
                E_CHAN:
                    pkt_data <= (sub == 3'd0) ? pkt_target
                                              : {CH_FMT_PHY,
                                                 12'h000};
                E_HDR:
                    pkt_data <= hdr_word({id_r, time_r}, sub);
                E_DATA:
                    pkt_data <= (widx < used_r) ? buf_mem[widx]
                                                : 16'h0;
                default:
                    pkt_data <= 16'h0;
            endcase
        end
    end

    // registers
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pkt_flags      <= FLAGS_RST;
            sel_reg        <= SEL_RST;
            frames_per_pkt <= FRAMES_RST;
            mask           <= '0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                REG_CTRL:
                begin
                    pkt_flags <= reg_wdata[7:0];
                    sel_reg   <= reg_wdata[CTRL_SEL];
                end
                REG_FRAMES:
                    frames_per_pkt <= reg_wdata[15:0];
                REG_MASK:
                    mask <= reg_wdata[IRQ_W-1:0];
                default:
                    mask <= mask;
            endcase
        end
    end

    always_comb
    begin
        ev           = '0;
        ev[IRQ_PKT]  = pkt_end;
        ev[IRQ_DROP] = refused || rx_overrun;
        ev[IRQ_ERR]  = finish && (next_id[ID_FAULT] || next_id[ID_CRC]);
        clr = (reg_wr && reg_addr == REG_STAT) ? reg_wdata[IRQ_W-1:0]
                                               : '0;
    end

    // a new event beats a clear written in the same cycle
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            stat <= '0;
        else
            stat <= (stat & ~clr) | ev;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            frames_total <= 32'h0;
        else if (frame_end)
            frames_total <= frames_total + 32'd1;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 32'h0;
            irq       <= 1'b0;
            time_fmt  <= 2'b00;
        end
        else
        begin
            irq      <= |(stat & mask);
            time_fmt <= pkt_flags[CTRL_FMT_LO +: 2];
            reg_rdata <= 32'h0;
            if (reg_rd)
            begin
                case (reg_addr)
                    REG_CTRL:
                        reg_rdata <= {23'h0, sel_reg, pkt_flags};
                    REG_FRAMES:
                        reg_rdata <= {16'h0, frames_per_pkt};
                    REG_STAT:
                        reg_rdata <= {22'h0, emit_st, cap_st, 3'h0,
                                      stat};
                    REG_MASK:
                        reg_rdata <= {29'h0, mask};
                    REG_COUNT:
                        reg_rdata <= frames_total;
                    default:
                        reg_rdata <= 32'h0;
                endcase
            end
        end
    end
endmodule : ffrp_packetizer

// [rtl/ffrp_pkg.sv]
// Notes on behaviour
// - channel word format field is zero
// - channel word low half counts frames
// - frames follow, each after its header
// - header is time low, time high, descriptor
// - bytes paired low first, odd filler high
// - default time is relative counter, padded
// - flag bit 6 selects absolute time
// - descriptor bit 31 marks framing fault
// - descriptor bit 30 marks crc failure
// - descriptor bit 29 marks earlier overrun
// - descriptor bit 28 set for complete frame
// - frame type only in complete mode
// - topology field reads passive
// - end delimiter code in payload mode
// - start delimiter code in payload mode
// - payload length capped at 2112 bytes
// - complete mode length is whole frame
// - length field always multiple of four
package ffrp_pkg;
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_FRAMES   = 8'h04;
    localparam logic [7:0]  REG_STAT     = 8'h08;
    localparam logic [7:0]  REG_MASK     = 8'h0c;
    localparam logic [7:0]  REG_COUNT    = 8'h10;
    localparam int          CTRL_ABS     = 6;
    localparam int          CTRL_FMT_LO  = 2;
    localparam int          CTRL_SEL     = 8;
    localparam logic [7:0]  FLAGS_RST    = 8'h00;
    localparam logic        SEL_RST      = 1'b1;
    localparam logic [15:0] FRAMES_RST   = 16'h0001;
    localparam logic [3:0]  CH_FMT_PHY   = 4'h0;
    localparam int          ID_FAULT     = 31;
    localparam int          ID_CRC       = 30;
    localparam int          ID_OVR       = 29;
    localparam int          ID_MODE      = 28;
    localparam int          ID_TYPE_LO   = 26;
    localparam int          ID_TOP_LO    = 24;
    localparam int          ID_EOF_LO    = 16;
    localparam int          ID_SOF_LO    = 12;
    localparam logic [1:0]  TOP_PASSIVE  = 2'h0;
    localparam logic [3:0]  SOF_MAX      = 4'ha;
    localparam logic [11:0] PAYLOAD_MAX  = 12'd2112;
    localparam logic [11:0] FRAME_MAX    = 12'd2148;
    localparam int          BUF_WORDS    = 1074;
    localparam logic [2:0]  HDR_LAST     = 3'd5;
    localparam int          IRQ_PKT      = 0;
    localparam int          IRQ_DROP     = 1;
    localparam int          IRQ_ERR      = 2;
    localparam int          IRQ_W        = 3;

    typedef enum logic [1:0] {
        C_IDLE = 2'b00,
        C_CAP  = 2'b01,
        C_HOLD = 2'b10
    } ffrp_cap_e;

    typedef enum logic [1:0] {
        E_IDLE = 2'b00,
        E_CHAN = 2'b01,
        E_HDR  = 2'b10,
        E_DATA = 2'b11
    } ffrp_emit_e;
endpackage : ffrp_pkg

// [dv/ffrp_port_model.sv]
`timescale 1ns/1ns
module ffrp_port_model (
    input  wire logic        mclk,
    output logic             rx_valid,
    output wire logic [7:0]  rx_byte,
    output logic             rx_first,
    output logic             rx_last,
    output logic             rx_crc_err,
    output logic             rx_eof_missing,
    output logic             rx_link_ctl,
    output logic      [2:0]  rx_eof_code,
    output logic      [3:0]  rx_sof_code,
    output logic             rx_overrun,
    output logic      [47:0] rtc,
    output wire logic [63:0] abs_time,
    input  wire logic [15:0] pkt_data,
    input  wire logic        pkt_valid,
    input  wire logic        pkt_first,
    input  wire logic        pkt_last
);
    logic [7:0]  byte_r;
    logic [47:0] tcap;
    logic [63:0] acap;
    logic [17:0] q[$];
    // an idle byte lane must not keep showing the last byte
    assign rx_byte = rx_valid ? byte_r : ~byte_r;
    assign abs_time = {rtc, 16'h5a5a};
    initial
    begin
        {rx_valid, rx_first, rx_last, rx_crc_err, rx_overrun} = 5'h0;
        {rx_eof_missing, rx_link_ctl, rx_eof_code, rx_sof_code} = 9'h0;
        rtc = 48'h0000_0123_4000;
        byte_r = 8'h00;
    end
    always @(posedge mclk)
    begin
        rtc <= rtc + 48'h1;
        if (rx_valid && rx_first)
        begin
            tcap <= rtc;
            acap <= abs_time;
        end
        if (pkt_valid)
            q.push_back({pkt_first, pkt_last, pkt_data});
    end
    task send(input int n, input logic [7:0] b0, input logic [3:0] sof,
              input logic [2:0] eof, input logic crc, lc, fe);
        repeat (2) @(posedge mclk);
        for (int i = 0; i < n; i++)
        begin
            rx_valid <= 1'b1;
            byte_r <= b0 + 8'(i);
            rx_first <= (i == 0);
            rx_last <= (i == n - 1);
            {rx_sof_code, rx_eof_code} <= {sof, eof};
            {rx_crc_err, rx_link_ctl, rx_eof_missing} <= {crc, lc, fe};
            @(posedge mclk);
        end
        {rx_valid, rx_first, rx_last} <= 3'h0;
        // let the captured time settle before the caller reads it
        @(posedge mclk);
    endtask : send
    task ovr;
        rx_overrun <= 1'b1;
        @(posedge mclk);
        rx_overrun <= 1'b0;
    endtask : ovr
endmodule : ffrp_port_model

// [dv/ffrp_packetizer_sva.sv]
`timescale 1ns/1ns
module ffrp_chk
    import ffrp_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic [1:0]        time_fmt,
    input wire logic [15:0]       pkt_data,
    input wire logic              pkt_valid,
    input wire logic              pkt_first,
    input wire logic              pkt_last
);
    logic [1:0]  fmt_w;
    logic [11:0] len_w;
    logic [3:0]  sof_w;
    assign fmt_w = reg_wdata[3:2];
    assign len_w = pkt_data[11:0];
    assign sof_w = pkt_data[15:12];
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // first header word of any frame
    sequence hdr_s;
        ($rose(pkt_valid) && !pkt_first) or (pkt_first ##2 1'b1);
    endsequence
    chan_fmt_a:
    assert property (pkt_first |=> pkt_valid && pkt_data == 16'h0000)
        else $error("channel word high half not zero");
    chan_count_a:
    assert property (pkt_first |-> pkt_valid && pkt_data != 16'h0000)
        else $error("channel word frame count zero");
    hdr_run_a:
    assert property (pkt_first |=> pkt_valid [*8])
        else $error("channel word and header not contiguous");
    top_rsvd_a:
    assert property (hdr_s ##5 1'b1 |-> pkt_data[9:3] == 7'h00)
        else $error("topology or reserved id bits set");
    len_quad_a:
    assert property (hdr_s ##4 1'b1 |-> pkt_data[1:0] == 2'b00)
        else $error("length not a multiple of four");
    pay_cap_a:
    assert property (hdr_s ##5 !pkt_data[12] |-> $past(len_w) <= 12'd2112)
        else $error("payload length above limit");
    sof_code_a:
    assert property (hdr_s ##5 !pkt_data[12] |-> $past(sof_w) <= 4'ha)
        else $error("start delimiter code reserved");
    comp_eof_a:
    assert property (hdr_s ##5 pkt_data[12] |-> pkt_data[2:0] == 3'h0)
        else $error("end code present in complete mode");
    pay_type_a:
    assert property (hdr_s ##5 !pkt_data[12] |-> pkt_data[11:10] == 2'h0)
        else $error("frame type present in payload mode");
    fmt_copy_a:
    assert property (reg_wr && reg_addr == REG_CTRL
                     |-> ##2 time_fmt == $past(fmt_w, 2))
        else $error("time format not taken from flags");
    last_word_a:
    assert property (pkt_last |-> pkt_valid && !pkt_first)
        else $error("packet end mark misplaced");
endmodule : ffrp_chk
bind ffrp_packetizer ffrp_chk chk_u (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .time_fmt(time_fmt), .pkt_data(pkt_data), .pkt_valid(pkt_valid),
    .pkt_first(pkt_first), .pkt_last(pkt_last));

// [dv/ffrp_packetizer_bench.sv]
`timescale 1ns/1ns
module ffrp_packetizer_bench;
    import ffrp_pkg::*;
    logic mclk, rst_n, reg_wr, reg_rd, rx_valid, rx_first, rx_last;
    logic rx_crc_err, rx_eof_missing, rx_link_ctl, rx_overrun;
    logic pkt_valid, pkt_first, pkt_last, irq;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [7:0]  rx_byte;
    logic [2:0]  rx_eof_code;
    logic [3:0]  rx_sof_code;
    logic [47:0] rtc;
    logic [63:0] abs_time;
    logic [1:0]  time_fmt;
    logic [15:0] pkt_data;
    int n_errors = 0, n_tests = 0, cyc = 0;
    ffrp_packetizer dut_u (.*);
    ffrp_port_model m_u (.*);
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task close_out;
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            close_out();
        end
    end
    task chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    task getw(input logic [17:0] e);
        int k;
        k = 0;
        while (m_u.q.size() == 0 && k < 300)
        begin
            @(posedge mclk);
            k++;
        end
        if (m_u.q.size() == 0)
            chk(32'hdead, {14'h0, e});
        else
            chk({14'h0, m_u.q.pop_front()}, {14'h0, e});
    endtask : getw
    function automatic logic [31:0] idw(input logic fe, ce, ov, cm, lc,
        input logic [2:0] eof, input logic [3:0] sof, input int n);
        logic [11:0] len;
        len = 12'((n + 3) / 4 * 4);
        return {fe || (n % 4 != 0), ce, ov, cm, 1'b0, cm & lc, 7'h00,
                cm ? 3'h0 : eof, cm ? 4'h0 : sof, len};
    endfunction : idw
    task xf(input logic f, l, input logic [15:0] cnt, input logic [63:0] t,
            input logic [31:0] id, input int n, input logic [7:0] b0);
        logic [7:0] lo, hi;
        int w;
        w = (n + 3) / 4 * 2;
        if (f)
        begin
            getw({2'b10, cnt});
            getw(18'h0);
        end
        for (int j = 0; j < 4; j++)
            getw({2'b00, t[16*j +: 16]});
        getw({2'b00, id[15:0]});
        getw({2'b00, id[31:16]});
        for (int j = 0; j < w; j++)
        begin
            lo = (2 * j < n) ? b0 + 8'(2 * j) : 8'h00;
            hi = (2 * j + 1 < n) ? b0 + 8'(2 * j + 1) : 8'h00;
            getw({1'b0, l && j == w - 1, hi, lo});
        end
    endtask : xf
    task t_reset;
        rd(REG_CTRL, 32'h100);
        rd(REG_FRAMES, 32'h1);
        rd(REG_MASK, 32'h0);
        wr(REG_COUNT, 32'h55);
        rd(REG_COUNT, 32'h0);
        rd(8'h40, 32'h0);
        chk(irq, 32'h0);
    endtask : t_reset
    task t_codes;
        logic [7:0] b;
        for (int k = 0; k < 11; k++)
        begin
            b = 8'h20 + 8'(k * 16);
            m_u.send(k + 1, b, 4'(k), 3'(k), k[0], 1'b0, k == 7);
            xf(1, 1, 16'h1, {16'h0, m_u.tcap}, idw(k == 7, k[0], 1'b0,
               1'b0, 1'b0, 3'(k), 4'(k), k + 1), k + 1, b);
        end
    endtask : t_codes
    task t_complete;
        wr(REG_CTRL, 32'h48);
        @(posedge mclk);
        #1 chk(time_fmt, 32'h2);
        m_u.send(6, 8'h61, 4'h3, 3'h5, 1'b0, 1'b1, 1'b0);
        xf(1, 1, 16'h1, m_u.acap, idw(0, 0, 0, 1, 1, 3'h5, 4'h3, 6),
           6, 8'h61);
        m_u.send(8, 8'h81, 4'h2, 3'h1, 1'b1, 1'b0, 1'b0);
        xf(1, 1, 16'h1, m_u.acap, idw(0, 1, 0, 1, 0, 3'h1, 4'h2, 8),
           8, 8'h81);
        wr(REG_CTRL, 32'h100);
    endtask : t_complete
    task t_multi;
        wr(REG_STAT, 32'h7);
        wr(REG_MASK, 32'h0);
        wr(REG_FRAMES, 32'h2);
        m_u.ovr();
        m_u.send(4, 8'h11, 4'h1, 3'h0, 1'b0, 1'b0, 1'b0);
        xf(1, 0, 16'h2, {16'h0, m_u.tcap}, idw(0, 0, 1, 0, 0, 3'h0, 4'h1, 4),
           4, 8'h11);
        m_u.send(4, 8'h31, 4'h6, 3'h3, 1'b0, 1'b0, 1'b0);
        xf(0, 1, 16'h2, {16'h0, m_u.tcap}, idw(0, 0, 0, 0, 0, 3'h3, 4'h6, 4),
           4, 8'h31);
        repeat (3) @(posedge mclk);
        chk(irq, 32'h0);
        wr(REG_MASK, 32'h1);
        repeat (3) @(posedge mclk);
        chk(irq, 32'h1);
        wr(REG_STAT, 32'h1);
        repeat (3) @(posedge mclk);
        chk(irq, 32'h0);
        rd(REG_STAT, 32'h2);
        rd(REG_COUNT, 32'hf);
    endtask : t_multi
    initial
    begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_codes();
        t_complete();
        t_multi();
        close_out();
    end
endmodule : ffrp_packetizer_bench
